// File: bench/interrogator_model.sv
`timescale 1ns/1ps
module interrogator_model (
  // clock
  input wire logic mclk,
  // decoded command toward the tag
  output logic cmd_valid,
  output tag_cmd_pkg::cmd_type cmd_code,
  output logic [1:0] cmd_bank,
  output logic [8:0] cmd_ptr,
  output logic [7:0] cmd_len,
  output logic [15:0] cmd_data,
  // front-end checks
  output logic cmd_handle_ok,
  output logic cmd_session_match,
  output logic cmd_slot_zero,
  output logic cmd_pwd_ok
);
  import tag_cmd_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd_code = CMD_INVALID;
    cmd_bank = 2'h0;
    cmd_ptr = 9'h000;
    cmd_len = 8'h00;
    cmd_data = 16'h0000;
    cmd_handle_ok = 1'b1;
    cmd_session_match = 1'b1;
    cmd_slot_zero = 1'b1;
    cmd_pwd_ok = 1'b0;
  end

  // one command per call; code, bank, pointer, count and data are chosen by the caller
  task automatic send(input cmd_type code, input logic [1:0] bank, input logic [8:0] ptr, input logic [7:0] len,
                      input logic [15:0] data);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_bank <= bank;
    cmd_ptr <= ptr;
    cmd_len <= len;
    cmd_data <= data;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    // released pointer, count and data lines must not keep showing the last command (code and bank keep their values)
    cmd_ptr <= ~ptr;
    cmd_len <= ~len;
    cmd_data <= ~data;
  endtask : send

  // password check result seen by the tag on the following commands
  task automatic set_pwd(input logic pwd_ok);
    @(posedge mclk);
    cmd_pwd_ok <= pwd_ok;
  endtask : set_pwd
endmodule : interrogator_model

// File: bench/tb_tag_cmd.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); fails++; end end
module tb_tag_cmd;
  import tag_cmd_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] sel_word = 16'h0000;
  logic cmd_valid, cmd_handle_ok, cmd_session_match, cmd_slot_zero, cmd_pwd_ok;
  cmd_type cmd_code;
  logic [1:0] cmd_bank;
  logic [8:0] cmd_ptr;
  logic [7:0] cmd_len;
  logic [15:0] cmd_data, rsp_data;
  logic rsp_valid, sel_match, sel_valid, err_flag;
  rsp_type rsp_kind;
  logic [7:0] rsp_err;
  tag_state_type tag_state;
  int fails = 0;
  int tests_run = 0;

  always #5 mclk = ~mclk;

  interrogator_model i_interrogator_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_handle_ok(cmd_handle_ok),
    .cmd_session_match(cmd_session_match), .cmd_slot_zero(cmd_slot_zero), .cmd_pwd_ok(cmd_pwd_ok));

  tag_cmd i_tag_cmd (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
    .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .cmd_data(cmd_data), .cmd_handle_ok(cmd_handle_ok),
    .cmd_session_match(cmd_session_match), .cmd_slot_zero(cmd_slot_zero), .cmd_pwd_ok(cmd_pwd_ok),
    .sel_word(sel_word), .rsp_valid(rsp_valid), .rsp_kind(rsp_kind), .rsp_err(rsp_err), .rsp_data(rsp_data),
    .sel_match(sel_match), .sel_valid(sel_valid), .tag_state(tag_state), .err_flag(err_flag));

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // answer is registered on the taking edge itself; look at it once settled
  task automatic cmd(input cmd_type code, input logic [8:0] ptr, input logic [7:0] len, input logic [15:0] data);
    i_interrogator_model.send(code, BANK_USER, ptr, len, data);
    #1;
  endtask : cmd

  task automatic carrier_drop();
    @(posedge mclk);
    srst <= 1'b1;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    #1;
    `CHK(tag_state, ST_READY)
    `CHK(err_flag, 1'b0)
    `CHK(rsp_valid, 1'b0)
  endtask : carrier_drop

  task automatic go_open();
    cmd(CMD_QUERY, 9'h000, 8'h00, 16'h0000);
    `CHK(tag_state, ST_REPLY)
    cmd(CMD_ACK, 9'h000, 8'h00, 16'h0000);
    `CHK(tag_state, ST_ACKED)
    cmd(CMD_REQ_RN, 9'h000, 8'h00, 16'h0000);
    `CHK(tag_state, ST_OPEN)
  endtask : go_open

  task automatic write_then_zero_reads();
    cmd(CMD_WRITE, 9'h01F, 8'h01, 16'hA5C3);
    `CHK(rsp_kind, RSP_SUCCESS)
    `CHK(err_flag, 1'b1)
    cmd(CMD_READ, 9'h01F, 8'h00, 16'h0000);
    `CHK(rsp_valid, 1'b1)
    `CHK(rsp_kind, RSP_ERROR)
    `CHK(rsp_err, ERR_OVERRUN)
    cmd(CMD_READ, 9'h01F, 8'h00, 16'h0000);
    `CHK(rsp_kind, RSP_DATA)
    `CHK(rsp_data, 16'hA5C3)
  endtask : write_then_zero_reads

  task automatic nonzero_count_read();
    cmd(CMD_WRITE, 9'h01F, 8'h01, 16'h3C5A);
    cmd(CMD_READ, 9'h01F, 8'h01, 16'h0000);
    `CHK(rsp_kind, RSP_DATA)
    `CHK(rsp_data, 16'h3C5A)
  endtask : nonzero_count_read

  task automatic intervening_write();
    cmd(CMD_WRITE, 9'h01F, 8'h01, 16'h0F0F);
    cmd(CMD_WRITE, 9'h005, 8'h01, 16'h1E2D);
    `CHK(err_flag, 1'b0)
    cmd(CMD_READ, 9'h005, 8'h00, 16'h0000);
    `CHK(rsp_kind, RSP_DATA)
    `CHK(rsp_data, 16'h1E2D)
    cmd(CMD_WRITE, 9'h020, 8'h01, 16'hFFFF);
    `CHK(rsp_err, ERR_OVERRUN)
    `CHK(err_flag, 1'b0)
  endtask : intervening_write

  task automatic select_in_ready();
    @(posedge mclk);
    sel_word <= 16'h8001;
    cmd(CMD_SELECT, 9'h1FE, 8'h01, 16'h8001);
    `CHK(sel_valid, 1'b1)
    `CHK(err_flag, 1'b1)
    `CHK(tag_state, ST_READY)
    cmd(CMD_SELECT, 9'h000, 8'h10, 16'h8001);
    `CHK(sel_match, 1'b0)
    cmd(CMD_SELECT, 9'h000, 8'h10, 16'h8001);
    `CHK(sel_match, 1'b1)
    cmd(CMD_SELECT, 9'h1FD, 8'h02, 16'h8001);
    `CHK(err_flag, 1'b1)
    cmd(CMD_WRITE, 9'h01F, 8'h01, 16'h1234);
    `CHK(err_flag, 1'b1)
    `CHK(tag_state, ST_READY)
    `CHK(rsp_valid, 1'b0)
  endtask : select_in_ready

  task automatic reply_timer_and_kill();
    cmd(CMD_QUERY, 9'h000, 8'h00, 16'h0000);
    repeat (T2_CYCLES + 2) @(posedge mclk);
    #1;
    `CHK(tag_state, ST_ARBITRATE)
    cmd(CMD_QUERY_REP, 9'h000, 8'h00, 16'h0000);
    `CHK(tag_state, ST_REPLY)
    `CHK(rsp_kind, RSP_RN16)
    cmd(CMD_INVALID, 9'h000, 8'h00, 16'h0000);
    `CHK(tag_state, ST_ARBITRATE)
    cmd(CMD_QUERY_REP, 9'h000, 8'h00, 16'h0000);
    cmd(CMD_ACK, 9'h000, 8'h00, 16'h0000);
    cmd(CMD_REQ_RN, 9'h000, 8'h00, 16'h0000);
    `CHK(tag_state, ST_OPEN)
    i_interrogator_model.set_pwd(1'b1);
    cmd(CMD_ACCESS, 9'h000, 8'h00, 16'h0000);
    `CHK(tag_state, ST_SECURED)
    `CHK(rsp_kind, RSP_HANDLE)
    cmd(CMD_LOCK, 9'h000, 8'h00, 16'h0000);
    `CHK(rsp_kind, RSP_SUCCESS)
    cmd(CMD_KILL, 9'h000, 8'h00, 16'h0000);
    `CHK(tag_state, ST_KILLED)
    cmd(CMD_WRITE, 9'h01F, 8'h01, 16'h0000);
    `CHK(err_flag, 1'b0)
    `CHK(rsp_valid, 1'b0)
    `CHK(tag_state, ST_KILLED)
    i_interrogator_model.set_pwd(1'b0);
  endtask : reply_timer_and_kill

  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    #1;
    `CHK(tag_state, ST_READY)
    `CHK(err_flag, 1'b0)
    go_open();
    write_then_zero_reads();
    nonzero_count_read();
    intervening_write();
    cmd(CMD_WRITE, 9'h01F, 8'h01, 16'h7777);
    carrier_drop();
    select_in_ready();
    reply_timer_and_kill();
    carrier_drop();
    tally_and_finish();
  end

  // the sequence needs a little over two thousand cycles, mostly the reply-timer wait
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_tag_cmd

// File: hdl/tag_cmd.sv
`timescale 1ns/1ps
module tag_cmd (
  // clock and reset (srst is carrier loss / power-up)
  input wire logic mclk,
  input wire logic srst,
  // decoded command from the air-link front end
  input wire logic cmd_valid,
  input wire tag_cmd_pkg::cmd_type cmd_code,
  input wire logic [1:0] cmd_bank,
  input wire logic [8:0] cmd_ptr,
  input wire logic [7:0] cmd_len,
  input wire logic [15:0] cmd_data,
  input wire logic cmd_handle_ok,
  input wire logic cmd_session_match,
  input wire logic cmd_slot_zero,
  input wire logic cmd_pwd_ok,
  // select comparison word, used for the user bank and the other banks
  input wire logic [15:0] sel_word,
  // reply to the modulator
  output logic rsp_valid,
  output tag_cmd_pkg::rsp_type rsp_kind,
  output logic [7:0] rsp_err,
  output logic [15:0] rsp_data,
  // select outcome and state view
  output logic sel_match,
  output logic sel_valid,
  output tag_cmd_pkg::tag_state_type tag_state,
  output logic err_flag
);
  import tag_cmd_pkg::*;

  tag_state_type st_q, st_d;
  logic flag_q, flag_d;
  logic rsp_valid_q, rsp_valid_d;
  rsp_type rsp_kind_q, rsp_kind_d;
  logic [7:0] rsp_err_q, rsp_err_d;
  logic sel_match_q, sel_match_d;
  logic sel_valid_q, sel_valid_d;
  logic [15:0] t2_q, t2_d;
  logic t2_wait_q, t2_wait_d;
  logic mem_wr;
  logic [15:0] mem_rd;
  logic [9:0] mask_end;
  logic user_ok;
  logic wr_last;
  logic sel_last;

  user_mem u_mem (
    .mclk(mclk),
    .srst(srst),
    .wr_en(mem_wr),
    .wr_addr(cmd_ptr[4:0]),
    .wr_data(cmd_data),
    .rd_addr(cmd_ptr[4:0]),
    .rd_data(mem_rd)
  );

  // the mask end that trips the flag is ptr + len, so ptr 1F0h with length 15 reaches 1FFh
  assign mask_end = 10'(cmd_ptr) + 10'(cmd_len);
  assign user_ok = cmd_bank == BANK_USER && cmd_ptr[8:5] == 4'h0;
  assign wr_last = cmd_code == CMD_WRITE && cmd_bank == BANK_USER && cmd_ptr == 9'(USER_LAST_WORD);
  assign sel_last = cmd_code == CMD_SELECT && cmd_bank == BANK_USER && cmd_len != 8'h00
                    && mask_end == 10'(USER_LAST_BIT);
  // writes need an open/secured tag with a valid handle
  assign mem_wr = cmd_valid && cmd_code == CMD_WRITE && user_ok && cmd_handle_ok
                  && (st_q == ST_OPEN || st_q == ST_SECURED);

  // state, reply and flag next values
  always_comb begin
    st_d = st_q;
    flag_d = flag_q;
    rsp_valid_d = 1'b0;
    rsp_kind_d = rsp_kind_q;
    rsp_err_d = rsp_err_q;
    sel_match_d = sel_match_q;
    sel_valid_d = 1'b0;
    t2_d = t2_q;
    t2_wait_d = t2_wait_q;
    if (t2_wait_q) begin
      if (t2_q == 16'h0000) begin
        t2_wait_d = 1'b0;
        // no interrogator answer within T2: fall back to arbitrate
        if (st_q == ST_REPLY || st_q == ST_ACKED) begin
          st_d = ST_ARBITRATE;
        end
      end else begin
        t2_d = t2_q - 16'h0001;
      end
    end
    if (cmd_valid && st_q != ST_KILLED) begin
      t2_wait_d = 1'b0;
      // any decoded command ends the flag's effect unless it sets it again
      flag_d = 1'b0;
      case (cmd_code)
        CMD_SELECT: begin
          sel_valid_d = 1'b1;
          if (flag_q && cmd_len != 8'h00) begin
            sel_match_d = 1'b0;
          end else if (cmd_bank == BANK_USER) begin
            sel_match_d = (mask_end[9:4] == 6'h00 || mask_end <= 10'(USER_LAST_BIT)) &&
                          (cmd_len == 8'h00 || sel_word == cmd_data);
          end else begin
            sel_match_d = sel_word == cmd_data;
          end
          if (sel_last) begin
            flag_d = 1'b1;
          end
          if (st_q != ST_READY) begin
            st_d = ST_READY;
          end
        end
        CMD_QUERY: begin
          st_d = cmd_session_match ? (cmd_slot_zero ? ST_REPLY : ST_ARBITRATE) : ST_READY;
          if (cmd_session_match && cmd_slot_zero) begin
            rsp_valid_d = 1'b1;
            rsp_kind_d = RSP_RN16;
            t2_wait_d = 1'b1;
            t2_d = 16'(T2_CYCLES);
          end
        end
        CMD_QUERY_REP, CMD_QUERY_ADJ: begin
          if (st_q == ST_ARBITRATE && cmd_slot_zero) begin
            st_d = ST_REPLY;
            rsp_valid_d = 1'b1;
            rsp_kind_d = RSP_RN16;
            t2_wait_d = 1'b1;
            t2_d = 16'(T2_CYCLES);
          end else if (st_q != ST_READY && st_q != ST_ARBITRATE) begin
            st_d = ST_READY;
          end
        end
        CMD_ACK: begin
          if (st_q == ST_REPLY && cmd_handle_ok) begin
            st_d = ST_ACKED;
            rsp_valid_d = 1'b1;
            rsp_kind_d = RSP_EPC;
          end else if (st_q != ST_READY) begin
            st_d = ST_ARBITRATE;
          end
        end
        CMD_NAK: begin
          if (st_q != ST_READY) begin
            st_d = ST_ARBITRATE;
          end
        end
        CMD_REQ_RN: begin
          if (cmd_handle_ok && st_q == ST_ACKED) begin
            st_d = cmd_pwd_ok ? ST_SECURED : ST_OPEN;
          end
          if (cmd_handle_ok && st_q != ST_READY && st_q != ST_ARBITRATE) begin
            rsp_valid_d = 1'b1;
            rsp_kind_d = RSP_HANDLE;
          end
        end
        CMD_READ: begin
          if (cmd_handle_ok && (st_q == ST_OPEN || st_q == ST_SECURED)) begin
            rsp_valid_d = 1'b1;
            if (flag_q && cmd_len == 8'h00) begin
              rsp_kind_d = RSP_ERROR;
              rsp_err_d = ERR_OVERRUN;
            end else if (cmd_bank == BANK_USER && !user_ok) begin
              rsp_kind_d = RSP_ERROR;
              rsp_err_d = ERR_OVERRUN;
            end else begin
              rsp_kind_d = RSP_DATA;
            end
          end
        end
        CMD_WRITE: begin
          if (wr_last) begin
            flag_d = 1'b1;
          end
          if (cmd_handle_ok && (st_q == ST_OPEN || st_q == ST_SECURED)) begin
            rsp_valid_d = 1'b1;
            rsp_kind_d = mem_wr ? RSP_SUCCESS : RSP_ERROR;
            rsp_err_d = mem_wr ? rsp_err_q : ERR_OVERRUN;
          end
        end
        CMD_KILL: begin
          if (cmd_handle_ok && cmd_pwd_ok && (st_q == ST_OPEN || st_q == ST_SECURED)) begin
            st_d = ST_KILLED;
            rsp_valid_d = 1'b1;
            rsp_kind_d = RSP_SUCCESS;
          end
        end
        CMD_ACCESS: begin
          if (cmd_handle_ok && st_q == ST_OPEN && cmd_pwd_ok) begin
            st_d = ST_SECURED;
          end
          if (cmd_handle_ok && (st_q == ST_OPEN || st_q == ST_SECURED)) begin
            rsp_valid_d = 1'b1;
            rsp_kind_d = RSP_HANDLE;
          end
        end
        CMD_LOCK, CMD_CUSTOM: begin
          if (cmd_handle_ok && st_q == ST_SECURED) begin
            rsp_valid_d = 1'b1;
            rsp_kind_d = RSP_SUCCESS;
          end
        end
        default: begin
          // invalid command: leave the reply and acknowledged states for arbitrate
          if (st_q == ST_REPLY || st_q == ST_ACKED) begin
            st_d = ST_ARBITRATE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= ST_READY;
      flag_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_kind_q <= RSP_NONE;
      rsp_err_q <= ERR_OTHER;
      sel_match_q <= 1'b0;
      sel_valid_q <= 1'b0;
      t2_q <= 16'h0000;
      t2_wait_q <= 1'b0;
    end else begin
      st_q <= st_d;
      flag_q <= flag_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_kind_q <= rsp_kind_d;
      rsp_err_q <= rsp_err_d;
      sel_match_q <= sel_match_d;
      sel_valid_q <= sel_valid_d;
      t2_q <= t2_d;
      t2_wait_q <= t2_wait_d;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_kind = rsp_kind_q;
  assign rsp_err = rsp_err_q;
  assign rsp_data = mem_rd;
  assign sel_match = sel_match_q;
  assign sel_valid = sel_valid_q;
  assign tag_state = st_q;
  assign err_flag = flag_q;

  sequence s_flag_write;
    cmd_valid && st_q != ST_KILLED && wr_last;
  endsequence

  sequence s_flag_select;
    cmd_valid && st_q != ST_KILLED && sel_last;
  endsequence

  AST_WRITE_SETS: assert property (@(posedge mclk) disable iff (srst)
    s_flag_write |=> err_flag) else $error("write to last word did not set flag");
  AST_SELECT_SETS: assert property (@(posedge mclk) disable iff (srst)
    s_flag_select |=> err_flag) else $error("select ending at last bit did not set flag");
  AST_READY_SETS: assert property (@(posedge mclk) disable iff (srst)
    (st_q == ST_READY && cmd_valid && wr_last) |=> err_flag && tag_state == ST_READY)
    else $error("flag not set in ready state");
  AST_READ_OVERRUN: assert property (@(posedge mclk) disable iff (srst)
    (flag_q && cmd_valid && cmd_code == CMD_READ && cmd_len == 8'h00 && cmd_handle_ok && st_q == ST_OPEN)
    |=> rsp_valid && rsp_kind == RSP_ERROR && rsp_err == ERR_OVERRUN) else $error("no overrun on flagged read");
  AST_SELECT_MISS: assert property (@(posedge mclk) disable iff (srst)
    (flag_q && cmd_valid && cmd_code == CMD_SELECT && cmd_len != 8'h00 && st_q != ST_KILLED)
    |=> sel_valid && !sel_match) else $error("flagged select matched");
  AST_RESET_CLEARS: assert property (@(posedge mclk)
    srst |=> !err_flag && tag_state == ST_READY) else $error("reset left flag or state");
  AST_READ_NONZERO: assert property (@(posedge mclk) disable iff (srst)
    (cmd_valid && cmd_code == CMD_READ && cmd_len != 8'h00 && user_ok && cmd_handle_ok && st_q == ST_OPEN)
    |=> rsp_kind == RSP_DATA) else $error("nonzero read not served");
  AST_OTHER_CLEARS: assert property (@(posedge mclk) disable iff (srst)
    (flag_q && cmd_valid && st_q != ST_KILLED && !wr_last && !sel_last) |=> !err_flag)
    else $error("flag survived another command");
  AST_STATE_ONEHOT: assert property (@(posedge mclk) disable iff (srst)
    $onehot(tag_state)) else $error("bad tag state");
  AST_KILLED_STAYS: assert property (@(posedge mclk) disable iff (srst)
    st_q == ST_KILLED |=> tag_state == ST_KILLED) else $error("killed tag left killed state");
  AST_KILLED_SILENT: assert property (@(posedge mclk) disable iff (srst)
    st_q == ST_KILLED |=> !rsp_valid && !sel_valid)
    else $error("killed tag replied");
  AST_T2_FALLBACK: assert property (@(posedge mclk) disable iff (srst)
    (t2_wait_q && t2_q == 16'h0000 && !cmd_valid && st_q == ST_REPLY) |=> tag_state == ST_ARBITRATE)
    else $error("reply timer expiry did not return to arbitrate");
  AST_WRITE_REFUSED: assert property (@(posedge mclk) disable iff (srst)
    (cmd_valid && cmd_code == CMD_WRITE && st_q != ST_OPEN && st_q != ST_SECURED) |=> !rsp_valid)
    else $error("write outside open or secured was answered");
endmodule : tag_cmd

// File: hdl/user_mem.sv
`timescale 1ns/1ps
module user_mem (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // write port
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  // read port
  input wire logic [4:0] rd_addr,
  output logic [15:0] rd_data
);
  import tag_cmd_pkg::*;

  logic [15:0] mem_q [USER_WORDS];
  logic [15:0] mem_d [USER_WORDS];
  logic [15:0] rd_q;
  logic [15:0] rd_d;

  // contents are nonvolatile in the real part, so srst leaves them alone
  genvar gi;
  generate
    for (gi = 0; gi < USER_WORDS; gi++) begin : g_word
      always_comb begin
        mem_d[gi] = mem_q[gi];
        if (wr_en && wr_addr == 5'(gi)) begin
          mem_d[gi] = wr_data;
        end
      end
      always_ff @(posedge mclk) begin
        mem_q[gi] <= mem_d[gi];
      end
    end
  endgenerate

  always_comb begin
    rd_d = mem_q[rd_addr];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_q <= 16'h0000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
endmodule : user_mem

// File: inc/tag_cmd_pkg.sv
package tag_cmd_pkg;

  // decoded command codes presented by the front end
  typedef enum logic [3:0] {
    CMD_QUERY = 4'h0,
    CMD_QUERY_REP = 4'h1,
    CMD_QUERY_ADJ = 4'h2,
    CMD_ACK = 4'h3,
    CMD_NAK = 4'h4,
    CMD_REQ_RN = 4'h5,
    CMD_SELECT = 4'h6,
    CMD_READ = 4'h7,
    CMD_WRITE = 4'h8,
    CMD_KILL = 4'h9,
    CMD_LOCK = 4'hA,
    CMD_ACCESS = 4'hB,
    CMD_CUSTOM = 4'hC,
    CMD_INVALID = 4'hF
  } cmd_type;

  // tag states, one-hot
  typedef enum logic [6:0] {
    ST_READY = 7'h01,
    ST_ARBITRATE = 7'h02,
    ST_REPLY = 7'h04,
    ST_ACKED = 7'h08,
    ST_OPEN = 7'h10,
    ST_SECURED = 7'h20,
    ST_KILLED = 7'h40
  } tag_state_type;

  // reply kinds
  typedef enum logic [2:0] {
    RSP_NONE = 3'h0,
    RSP_RN16 = 3'h1,
    RSP_EPC = 3'h2,
    RSP_HANDLE = 3'h3,
    RSP_DATA = 3'h4,
    RSP_ERROR = 3'h5,
    RSP_SUCCESS = 3'h6
  } rsp_type;

  localparam logic [1:0] BANK_USER = 2'h3;
  localparam int USER_WORDS = 32;
  localparam logic [4:0] USER_LAST_WORD = 5'h1F;
  localparam logic [8:0] USER_LAST_BIT = 9'h1FF;
  localparam logic [7:0] ERR_OVERRUN = 8'h03;
  localparam logic [7:0] ERR_OTHER = 8'h00;
  // T2 reply-wait window
  localparam int T2_NS = 20000;
  localparam int CLK_NS = 10;
  localparam int T2_CYCLES = T2_NS / CLK_NS;

endpackage : tag_cmd_pkg
